/* File: hdl/ssc_serial_id_regs.sv */
// I2C target returning a checksummed 64-bit serial number and holding the configuration registers.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - The full serial number takes two command transactions, each write then read.
// - First transaction writes command 0xFA then 0x0F, each acknowledged.
// - First response sends upper four serial bytes, each followed by a checksum.
// - Second transaction writes command 0xFC then 0xC9, each acknowledged.
// - Second response sends lower bytes in pairs plus checksum; host ends with NACK, stop.
// - Serial number is 64 bits: upper four bytes then lower four bytes.
// - Top byte of the lower half is a part code chosen by parameter.
// - Reserved configuration bits read at their fixed values and ignore writes.
// - Resolution code sits in bit 7 and bit 0 of register 1.
// - Bit 6 of register 1 is a read-only low supply flag.
// - Bit 2 of register 1 turns the heater on.
// - Bit 6 of register 2 selects no-hold auxiliary measurement mode.
// - Bit 5 of register 2 enables auxiliary linearization correction.
// - Bit 4 of register 2 selects fast converter timing.
// - Bit 2 of register 2 enables converter input buffering.
// - Bit 1 of register 2 selects supply rail instead of internal reference.
// - Bit 0 of register 2 drives the auxiliary pin level.
// - Auxiliary drive bit resets to the pin level seen at power-up.
// - The strapped pin level sets the address lowest bit, then pin drives out.
module ssc_serial_id_regs
    import ssc_pkg::*;
#(
    parameter logic [63:0] SERIAL_NUMBER = 64'h0123_4567_5A9B_CDEF,
    parameter logic [7:0]  CRC_POLY      = 8'h31,
    parameter logic [7:0]  CRC_INIT      = 8'h00
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       sclClk,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       addrStrapAuxIn,
    output logic            auxDriveOut,
    output logic            auxDriveOe,
    input  wire logic       supplyLowIn,
    output logic [1:0]      resolutionSelect,
    output logic            supplyLowFlag,
    output logic            heaterOn,
    output logic [3:0]      heaterLevel,
    output logic            auxNoHold,
    output logic            auxLinearizeEn,
    output logic            adcSpeedSelect,
    output logic            adcInputBuffered,
    output logic            adcRefSelect,
    output logic            auxDriveLevel
);

    // The checksum shift needs a polynomial with its constant term set.
    if (CRC_POLY[0] != 1'b1) begin : polyCheck
        $error("CRC_POLY must have bit 0 set");
    end

    ssc_core_t        cq;
    ssc_core_t        cn;
    ssc_link_t        lq;
    ssc_link_t        ln;
    logic             linkRst;
    logic             wrEv;
    logic             startTgl;
    logic             startNow;
    logic             addrHit;
    logic             loadNow;
    logic             wantLow;
    logic             sdaOeQ;
    logic [3:0]       loadIdx;
    logic [7:0]       fullByte;
    logic [7:0]       crcBase;
    logic [8:0]       resp;
    logic [CFG_W-1:0] cfgBundle;

    // ************************************************************
    // Functions
    // ************************************************************

    // Writes only touch writable bits; the rest keep their fixed value.
    function automatic logic [7:0] mergeW(input logic [7:0] old, input logic [7:0] d,
                                          input logic [7:0] m);
        return (old & ~m) | (d & m);
    endfunction

    // One byte of CRC, most significant data bit first.
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic       fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[7] ^ d[i];
            r = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    // Byte to send at a response position; bit 8 set means no CRC update.
    function automatic logic [8:0] respByte(input ssc_sel_t sel, input logic [3:0] idx,
                                            input logic [7:0] crc,
                                            input logic [CFG_W-1:0] cfg);
        logic [2:0] k;
        respByte = {1'b1, 8'hFF};
        k = 3'd0;
        case (sel)
            SEL_SER_A: begin
                if (idx < SER_A_LEN) begin
                    if (idx[0]) begin
                        respByte = {1'b1, crc};
                    end else begin
                        k = {1'b0, idx[2:1]};
                        respByte = {1'b0, SERIAL_NUMBER[63 - 8 * k -: 8]};
                    end
                end
            end
            SEL_SER_B: begin
                if (idx == SER_B_CRC0 || idx == SER_B_CRC1) begin
                    respByte = {1'b1, crc};
                end else if (idx < SER_B_LEN) begin
                    k = (idx < SER_B_CRC0) ? idx[2:0] : idx[2:0] - 3'd1;
                    respByte = {1'b0, SERIAL_NUMBER[31 - 8 * k -: 8]};
                end
            end
            SEL_REG1: if (idx == 4'd0) respByte = {1'b1, cfg[CFG_REG1 +: 8]};
            SEL_REG2: if (idx == 4'd0) respByte = {1'b1, cfg[CFG_REG2 +: 8]};
            SEL_REG3: if (idx == 4'd0) respByte = {1'b1, cfg[CFG_REG3 +: 8]};
            default: respByte = {1'b1, 8'hFF};
        endcase
    endfunction

    // ************************************************************
    // Core clock domain: pins, straps and configuration registers
    // ************************************************************

    assign linkRst = cq.linkRst;
    assign wrEv = (cq.wrSync[2] == cq.wrSync[1]) && (cq.wrSync[2] != cq.wrSeen);
    assign cfgBundle = {cq.strapAddr, cq.reg1, cq.reg2, cq.reg3};

    // Next core state; the link holds write data steady across the toggle crossing.
    always_comb begin
        cn = cq;
        cn.linkRst = 1'b0;
        cn.strapSync = {cq.strapSync[1:0], addrStrapAuxIn};
        cn.supSync = {cq.supSync[1:0], supplyLowIn};
        cn.strapFill = cq.strapFill + {1'b0, cq.strapFill != STRAP_FILL}; // Reset zeros are no strap.
        cn.wrSync = {cq.wrSync[1:0], lq.wrTgl};
        if (wrEv) begin
            cn.wrSeen = cq.wrSync[2];
            case (lq.wrSel)
                2'd1: cn.reg1 = mergeW(cq.reg1, lq.wrData, REG1_WMASK);
                2'd2: cn.reg2 = mergeW(cq.reg2, lq.wrData, REG2_WMASK);
                2'd3: cn.reg3 = mergeW(cq.reg3, lq.wrData, REG3_WMASK);
                default: cn.reg3 = cq.reg3;
            endcase
        end
        if (cq.supSync[2] == cq.supSync[1]) begin
            cn.reg1[BIT_SUPPLY] = cq.supSync[2];
        end
        if (!cq.strapDone && cq.strapFill == STRAP_FILL
            && cq.strapSync[2] == cq.strapSync[1]) begin
            cn.strapDone = 1'b1;
            cn.strapAddr = cq.strapSync[2];
            cn.reg2[BIT_AUXDRV] = cq.strapSync[2];
        end
    end

    // Core state register.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cq <= CORE_RESET;
        end else begin
            cq <= cn;
        end
    end

    assign resolutionSelect = {cq.reg1[BIT_RES_HI], cq.reg1[BIT_RES_LO]};
    assign supplyLowFlag    = cq.reg1[BIT_SUPPLY];
    assign heaterOn         = cq.reg1[BIT_HEATER];
    assign heaterLevel      = cq.reg3[HEATER_LSB +: 4];
    assign auxNoHold        = cq.reg2[BIT_NO_HOLD];
    assign auxLinearizeEn   = cq.reg2[BIT_LINEARIZE];
    assign adcSpeedSelect   = cq.reg2[BIT_SPEED];
    assign adcInputBuffered = cq.reg2[BIT_INBUF];
    assign adcRefSelect     = cq.reg2[BIT_REFSEL];
    assign auxDriveLevel    = cq.reg2[BIT_AUXDRV];
    assign auxDriveOut      = cq.reg2[BIT_AUXDRV];
    assign auxDriveOe       = cq.strapDone;

    // ************************************************************
    // Link clock domain: I2C target engine
    // ************************************************************

    // Start is SDA falling with SCL high; the next SCL rise is far later, so a toggle suffices.
    always_ff @(negedge sdaIn or posedge linkRst) begin
        if (linkRst) begin
            startTgl <= 1'b0;
        end else if (sclClk) begin
            startTgl <= ~startTgl;
        end
    end

    // Next link state, evaluated at each SCL rise.
    always_comb begin
        ln = lq;
        loadNow = 1'b0;
        loadIdx = lq.byteIdx;
        crcBase = lq.crc;
        resp = {1'b1, 8'hFF};
        fullByte = {lq.shiftIn[6:0], sdaIn};
        startNow = (startTgl != lq.startSeen);
        addrHit = (fullByte[7:1] == {TGT_ADDR_HI, lq.cfgUse[CFG_STRAP]});
        ln.cfgSync = {lq.cfgSync[1], lq.cfgSync[0], cfgBundle};
        if (lq.cfgSync[2] == lq.cfgSync[1]) begin
            ln.cfgUse = lq.cfgSync[2];
        end
        if (startNow) begin
            ln.startSeen = startTgl;
            ln.phase = LP_ADDR;
            ln.bitCnt = 4'd1;
            ln.shiftIn = {7'h00, sdaIn};
            ln.ackDrive = 1'b0;
        end else if (lq.bitCnt == ACK_SLOT && lq.phase != LP_READ) begin
            ln.bitCnt = 4'd0;
            ln.ackDrive = 1'b0;
            if (lq.phase == LP_ADDR && lq.isRead) begin
                ln.phase = LP_READ;
                loadNow = 1'b1;
                loadIdx = 4'd0;
                crcBase = CRC_INIT;
            end
        end else begin
            case (lq.phase)
                LP_IDLE: ln.bitCnt = lq.bitCnt;
                LP_READ: begin
                    if (lq.bitCnt != ACK_SLOT) begin
                        ln.bitCnt = lq.bitCnt + 4'd1;
                    end else if (!sdaIn) begin
                        loadNow = 1'b1;
                        ln.bitCnt = 4'd0;
                    end else begin
                        ln.phase = LP_IDLE;
                        ln.bitCnt = 4'd0;
                    end
                end
                default: begin
                    ln.shiftIn = fullByte;
                    if (lq.bitCnt != LAST_BIT) begin
                        ln.bitCnt = lq.bitCnt + 4'd1;
                    end else begin
                        ln.bitCnt = ACK_SLOT;
                        case (lq.phase)
                            LP_ADDR: begin
                                if (!addrHit) begin
                                    ln.phase = LP_IDLE;
                                end else begin
                                    ln.ackDrive = 1'b1;
                                    ln.isRead = fullByte[0];
                                    if (!fullByte[0]) begin
                                        ln.phase = LP_CMD1;
                                        ln.sel = SEL_NONE;
                                    end
                                end
                            end
                            LP_CMD1: begin
                                ln.cmdHi = fullByte;
                                ln.ackDrive = 1'b1;
                                ln.phase = LP_IDLE;
                                case (fullByte)
                                    CMD_SER_A_HI, CMD_SER_B_HI: ln.phase = LP_CMD2;
                                    CMD_RD_REG1: ln.sel = SEL_REG1;
                                    CMD_RD_REG2: ln.sel = SEL_REG2;
                                    CMD_RD_REG3: ln.sel = SEL_REG3;
                                    CMD_WR_REG1, CMD_WR_REG2, CMD_WR_REG3: begin
                                        ln.wrSel = fullByte[2:1] + 2'd1;
                                        ln.phase = LP_WDATA;
                                    end
                                    default: ln.ackDrive = 1'b0;
                                endcase
                            end
                            LP_CMD2: begin
                                ln.phase = LP_IDLE;
                                ln.ackDrive = 1'b1;
                                if (lq.cmdHi == CMD_SER_A_HI && fullByte == CMD_SER_A_LO) begin
                                    ln.sel = SEL_SER_A;
                                end else if (lq.cmdHi == CMD_SER_B_HI
                                             && fullByte == CMD_SER_B_LO) begin
                                    ln.sel = SEL_SER_B;
                                end else begin
                                    ln.ackDrive = 1'b0;
                                end
                            end
                            LP_WDATA: begin
                                ln.wrData = fullByte;
                                ln.wrTgl = ~lq.wrTgl;
                                ln.ackDrive = 1'b1;
                            end
                            default: ln.phase = LP_IDLE;
                        endcase
                    end
                end
            endcase
        end
        if (loadNow) begin
            resp = respByte(lq.sel, loadIdx, crcBase, lq.cfgUse);
            ln.txByte = resp[7:0];
            ln.crc = resp[8] ? crcBase : crc8(crcBase, resp[7:0]);
            ln.byteIdx = (loadIdx == 4'hF) ? loadIdx : loadIdx + 4'd1;
        end
    end

    // Link state register; the link reset comes from a core flop, so it is glitch free.
    always_ff @(posedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            lq <= LINK_RESET;
        end else begin
            lq <= ln;
        end
    end

    // SDA only changes while SCL is low, so drive is taken at the falling edge.
    assign wantLow = lq.ackDrive
                   | (lq.phase == LP_READ && lq.bitCnt != ACK_SLOT && !lq.txByte[~lq.bitCnt[2:0]]);

    always_ff @(negedge sclClk or posedge linkRst) begin
        if (linkRst) begin
            sdaOeQ <= 1'b0;
        end else begin
            sdaOeQ <= wantLow;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaOeQ;

    // ************************************************************
    // Assertions
    // ************************************************************

    reserved_bits_fixed_a : assert property (@(posedge core_clk) disable iff (reset)
        cq.reg1[5:3] == 3'b111 && cq.reg1[1] && cq.reg2[3] && !cq.reg2[7] && cq.reg3[7:4] == 4'h0)
        else $error("reserved bits changed");
    res_write_a : assert property (@(posedge core_clk) disable iff (reset)
        wrEv && lq.wrSel == 2'd1 |=> resolutionSelect == {$past(lq.wrData[7]), $past(lq.wrData[0])})
        else $error("resolution code not split across bits 7 and 0");
    heater_write_a : assert property (@(posedge core_clk) disable iff (reset)
        wrEv && lq.wrSel == 2'd1 |=> heaterOn == $past(lq.wrData[2]))
        else $error("heater enable not taken from bit 2");
    supply_flag_a : assert property (@(posedge core_clk) disable iff (reset)
        cq.supSync[2] == cq.supSync[1] |=> supplyLowFlag == $past(cq.supSync[2]))
        else $error("supply flag does not follow pin");
    aux_mode_a : assert property (@(posedge core_clk) disable iff (reset)
        wrEv && lq.wrSel == 2'd2
        |=> {auxNoHold, auxLinearizeEn, adcSpeedSelect} == $past(lq.wrData[6:4]))
        else $error("aux mode bits not written");
    adc_cfg_a : assert property (@(posedge core_clk) disable iff (reset)
        wrEv && lq.wrSel == 2'd2 && cq.strapDone
        |=> {adcInputBuffered, adcRefSelect, auxDriveLevel} == $past(lq.wrData[2:0]))
        else $error("converter bits not written");
    strap_catch_a : assert property (@(posedge core_clk) disable iff (reset)
        $rose(auxDriveOe) |-> auxDriveLevel == $past(cq.strapSync[2]) && cq.strapAddr == auxDriveLevel)
        else $error("aux drive reset not equal to strap");
    addr_ack_a : assert property (@(posedge sclClk) disable iff (linkRst)
        lq.phase == LP_ADDR && lq.bitCnt == LAST_BIT && !startNow && addrHit
        |=> lq.ackDrive && lq.bitCnt == ACK_SLOT)
        else $error("address match not acknowledged");
    crc_slot_a : assert property (@(posedge sclClk) disable iff (linkRst)
        loadNow && lq.sel == SEL_SER_A && loadIdx[0] && loadIdx < SER_A_LEN
        |=> lq.txByte == $past(crcBase))
        else $error("checksum slot carries wrong byte");
    part_code_a : assert property (@(posedge sclClk) disable iff (linkRst)
        loadNow && lq.sel == SEL_SER_B && loadIdx == 4'd0 |=> lq.txByte == SERIAL_NUMBER[31:24])
        else $error("second half does not open with part code");
    nack_end_a : assert property (@(posedge sclClk) disable iff (linkRst)
        lq.phase == LP_READ && lq.bitCnt == ACK_SLOT && sdaIn && !startNow
        |=> lq.phase == LP_IDLE ##0 !wantLow)
        else $error("read did not stop after NACK");

endmodule
`default_nettype wire

/* File: hdl/ssc_pkg.sv */
// Constants, enumerations and state types for the serial id and configuration block.
package ssc_pkg;

    // Serial number command pairs and register access commands.
    localparam logic [7:0] CMD_SER_A_HI = 8'hFA;
    localparam logic [7:0] CMD_SER_A_LO = 8'h0F;
    localparam logic [7:0] CMD_SER_B_HI = 8'hFC;
    localparam logic [7:0] CMD_SER_B_LO = 8'hC9;
    localparam logic [7:0] CMD_WR_REG1  = 8'hA0;
    localparam logic [7:0] CMD_RD_REG1  = 8'hA1;
    localparam logic [7:0] CMD_WR_REG2  = 8'hA2;
    localparam logic [7:0] CMD_RD_REG2  = 8'hA3;
    localparam logic [7:0] CMD_WR_REG3  = 8'hA4;
    localparam logic [7:0] CMD_RD_REG3  = 8'hA5;

    // Upper six bits of the target address; the strap gives the lowest.
    localparam logic [5:0] TGT_ADDR_HI  = 6'h20;

    // Register reset values and writable-bit masks.
    localparam logic [7:0] REG1_RESET   = 8'h3A;
    localparam logic [7:0] REG2_RESET   = 8'h08;
    localparam logic [7:0] REG3_RESET   = 8'h00;
    localparam logic [7:0] REG1_WMASK   = 8'h85;
    localparam logic [7:0] REG2_WMASK   = 8'h77;
    localparam logic [7:0] REG3_WMASK   = 8'h0F;

    // Field positions.
    localparam int BIT_RES_HI    = 7;
    localparam int BIT_SUPPLY    = 6;
    localparam int BIT_HEATER    = 2;
    localparam int BIT_RES_LO    = 0;
    localparam int BIT_NO_HOLD   = 6;
    localparam int BIT_LINEARIZE = 5;
    localparam int BIT_SPEED     = 4;
    localparam int BIT_INBUF     = 2;
    localparam int BIT_REFSEL    = 1;
    localparam int BIT_AUXDRV    = 0;
    localparam int HEATER_LSB    = 0;

    // Response framing, bit counting and the strap sync fill count.
    localparam logic [3:0] SER_A_LEN  = 4'd8;
    localparam logic [3:0] SER_B_LEN  = 4'd6;
    localparam logic [3:0] SER_B_CRC0 = 4'd2;
    localparam logic [3:0] SER_B_CRC1 = 4'd5;
    localparam logic [3:0] LAST_BIT   = 4'd7;
    localparam logic [3:0] ACK_SLOT   = 4'd8;
    localparam logic [1:0] STRAP_FILL = 2'h3;

    // Configuration bundle passed to the link side: strap, reg1, reg2, reg3.
    localparam int CFG_W     = 25;
    localparam int CFG_STRAP = 24;
    localparam int CFG_REG1  = 16;
    localparam int CFG_REG2  = 8;
    localparam int CFG_REG3  = 0;

    typedef enum logic [2:0] {LP_IDLE, LP_ADDR, LP_CMD1, LP_CMD2, LP_WDATA, LP_READ} ssc_phase_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_SER_A, SEL_SER_B, SEL_REG1, SEL_REG2, SEL_REG3} ssc_sel_t;

    typedef struct packed {
        logic [2:0] strapSync;
        logic [1:0] strapFill;
        logic [2:0] supSync;
        logic [2:0] wrSync;
        logic       wrSeen;
        logic       strapDone;
        logic       strapAddr;
        logic [7:0] reg1;
        logic [7:0] reg2;
        logic [7:0] reg3;
        logic       linkRst;
    } ssc_core_t;

    typedef struct packed {
        ssc_phase_t            phase;
        ssc_sel_t              sel;
        logic [3:0]            bitCnt;
        logic [7:0]            shiftIn;
        logic                  isRead;
        logic [7:0]            cmdHi;
        logic [3:0]            byteIdx;
        logic [7:0]            crc;
        logic [7:0]            txByte;
        logic                  ackDrive;
        logic                  startSeen;
        logic                  wrTgl;
        logic [1:0]            wrSel;
        logic [7:0]            wrData;
        logic [2:0][CFG_W-1:0] cfgSync;
        logic [CFG_W-1:0]      cfgUse;
    } ssc_link_t;

    localparam ssc_core_t CORE_RESET = '{reg1: REG1_RESET, reg2: REG2_RESET, reg3: REG3_RESET,
                                         linkRst: 1'b1, default: '0};
    localparam ssc_link_t LINK_RESET = '{phase: LP_IDLE, sel: SEL_NONE, default: '0};

endpackage

/* File: verification/ssc_i2c_host.sv */
// I2C host model for the serial id and configuration block.
`timescale 1ns/100ps
`default_nettype none
module ssc_i2c_host (
    output logic     scl,
    output logic     sda,
    input wire logic dutOe
);
    logic hostLow = 1'b0;
    // The pull-up holds the wire high unless a party pulls it low.
    assign sda = !(hostLow || dutOe);
    initial scl = 1'b1;
    // Data changes only while SCL is low, so no false start or stop is made.
    task automatic bitx(input logic b, output logic s);
        hostLow = !b;
        #16 scl = 1'b1;
        #16 s = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic start;
        hostLow = 1'b0;
        #16 scl = 1'b1;
        #16 hostLow = 1'b1;
        #16 scl = 1'b0;
        #16;
    endtask
    task automatic stop;
        hostLow = 1'b1;
        #16 scl = 1'b1;
        #16 hostLow = 1'b0;
        #32;
    endtask
    // Eight bits, then the acknowledge slot; ha high releases or refuses it.
    task automatic xfer(input logic [7:0] w, input logic ha, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bitx(w[i], q[i]);
        bitx(ha, ack);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the serial id and configuration block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import ssc_pkg::*;
    localparam logic [63:0] SN = 64'h0123_4567_5A9B_CDEF;
    localparam logic [7:0] MSK [3] = '{REG1_WMASK, REG2_WMASK, REG3_WMASK};
    localparam logic [7:0] RST [3] = '{REG1_RESET, REG2_RESET, REG3_RESET};
    logic       core_clk, reset, supLow, sdaOe, sdaO, auxOut, auxOe, supFlag, htr, a;
    logic       noHold, lin, spd, inBuf, refSel, auxLvl;
    logic [1:0] resSel;
    logic [3:0] htrLvl;
    logic [7:0] r;
    wire        scl, sda;
    wire        pad = auxOe ? auxOut : 1'b1;
    int         err_total = 0, n_checks = 0, cyc = 0;
    ssc_serial_id_regs #(.SERIAL_NUMBER(SN)) ssc_serial_id_regs_i (.core_clk(core_clk),
        .reset(reset), .sclClk(scl), .sdaIn(sda), .sdaOut(sdaO), .sdaOe(sdaOe),
        .addrStrapAuxIn(pad), .auxDriveOut(auxOut), .auxDriveOe(auxOe), .supplyLowIn(supLow),
        .resolutionSelect(resSel), .supplyLowFlag(supFlag), .heaterOn(htr),
        .heaterLevel(htrLvl), .auxNoHold(noHold), .auxLinearizeEn(lin), .adcSpeedSelect(spd),
        .adcInputBuffered(inBuf), .adcRefSelect(refSel), .auxDriveLevel(auxLvl));
    ssc_i2c_host ssc_i2c_host_i (.scl(scl), .sda(sda), .dutOe(sdaOe));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
        c ^= d;
        repeat (8) c = c[7] ? (c << 1) ^ 8'h31 : c << 1;
        return c;
    endfunction
    task automatic wb(logic [7:0] w);
        ssc_i2c_host_i.xfer(w, 1'b1, r, a);
        chk("ack", 8'h00, 8'(a));
    endtask
    task automatic rd(logic [7:0] c, logic [7:0] e);
        ssc_i2c_host_i.start;
        wb(8'h82);
        wb(c);
        ssc_i2c_host_i.start;
        wb(8'h83);
        ssc_i2c_host_i.xfer(8'hFF, 1'b1, r, a);
        ssc_i2c_host_i.stop;
        chk("reg", e, r);
    endtask
    task automatic wr(logic [7:0] c, logic [7:0] d);
        ssc_i2c_host_i.start;
        wb(8'h82);
        wb(c);
        wb(d);
        ssc_i2c_host_i.stop;
        repeat (20) @(negedge core_clk);
    endtask
    task automatic t_reset;
        chk("pin", 8'h07, 8'({auxOe, auxOut, auxLvl}));
        chk("sdaOut", 8'h00, 8'(sdaO));
        chk("cfg", 8'h00, 8'({resSel, htr, htrLvl}));
        for (int i = 0; i < 3; i++) rd(CMD_RD_REG1 + 8'(2 * i), RST[i] | 8'(i == 1));
    endtask
    task automatic t_regs;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 3; i++) begin
                wr(CMD_WR_REG1 + 8'(2 * i), {8{k == 0}});
                rd(CMD_RD_REG1 + 8'(2 * i), (MSK[i] & {8{k == 0}}) | (RST[i] & ~MSK[i]));
            end
            chk("cfg", {8{k == 0}} & 8'h7F, 8'({resSel, htr, htrLvl}));
            chk("aux", {8{k == 0}} & 8'h3F, 8'({noHold, lin, spd, inBuf, refSel, auxLvl}));
        end
    endtask
    task automatic t_supply;
        @(negedge core_clk);
        supLow = 1'b1;
        repeat (20) @(negedge core_clk);
        chk("flag", 8'h01, 8'(supFlag));
        rd(CMD_RD_REG1, 8'h7A);
        wr(CMD_WR_REG1, r);
        wr(CMD_WR_REG1, 8'h00);
        rd(CMD_RD_REG1, 8'h7A);
    endtask
    task automatic t_serial;
        logic [7:0] c, e;
        int j;
        for (int k = 0; k < 2; k++) begin
            j = 0;
            c = 8'h00;
            ssc_i2c_host_i.start;
            wb(8'h82);
            wb(k ? CMD_SER_B_HI : CMD_SER_A_HI);
            wb(k ? CMD_SER_B_LO : CMD_SER_A_LO);
            ssc_i2c_host_i.start;
            wb(8'h83);
            for (int i = 0; i < 8 - 2 * k; i++) begin
                ssc_i2c_host_i.xfer(8'hFF, 1'(i == 7 - 2 * k), r, a);
                if (k ? i % 3 == 2 : i % 2 == 1) chk("crc", c, r);
                else begin
                    e = SN[63 - 8 * (4 * k + j) -: 8];
                    chk("serial", e, r);
                    c = crc8(c, e);
                    j++;
                end
            end
            ssc_i2c_host_i.stop;
        end
    endtask
    task automatic t_refuse;
        ssc_i2c_host_i.start;
        ssc_i2c_host_i.xfer(8'h80, 1'b1, r, a);
        chk("addr nack", 8'h01, 8'(a));
        ssc_i2c_host_i.stop;
        ssc_i2c_host_i.start;
        wb(8'h82);
        wb(CMD_SER_A_HI);
        ssc_i2c_host_i.xfer(CMD_SER_B_LO, 1'b1, r, a);
        chk("cmd nack", 8'h01, 8'(a));
        ssc_i2c_host_i.stop;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // A hang is cut short well past the expected run length.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run;
        end
    end
    // Main sequence, each scenario reporting as it ends.
    initial begin
        reset = 1'b1;
        supLow = 1'b0;
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        repeat (20) @(negedge core_clk);
        t_reset;
        $display("reset test done");
        t_regs;
        $display("register test done");
        t_serial;
        $display("serial test done");
        t_refuse;
        $display("refuse test done");
        t_supply;
        $display("supply test done");
        complete_run;
    end
endmodule
`default_nettype wire
